// File: rtl/mapped_dram_access_refresh.sv
// DRAM strobe generation, address split and refresh timer behind the data-memory bus
`timescale 1ns/100ps
`default_nettype none
module mapped_dram_access_refresh (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_resetn,
    // Processor data-memory bus pins
    input  wire logic        i_data_memory_select_n,
    input  wire logic        i_rd_n,
    input  wire logic        i_wr_n,
    input  wire logic [13:0] i_addr,
    input  wire logic [15:0] i_data,
    output logic      [15:0] o_data,
    output logic             o_data_oe,
    // DRAM control pins
    output logic             o_ras_n,
    output logic             o_cas_n,
    output logic             o_write_n,
    output logic             o_oe_n,
    output logic      [9:0]  o_dram_addr,
    // Status
    output logic             o_ras_overtime,
    output logic             o_refresh_tick
);
    //=================================================================
    // Reset release through two flops
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge i_clk_sys or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rst_n = rst_sync_reg;

    //=================================================================
    // Pin synchronisers; first stage read only by second stage
    logic [33:0] pin_meta_reg;
    logic [33:0] pin_sync_reg;
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= {3'h7, 31'h00000000};
            pin_sync_reg <= {3'h7, 31'h00000000};
        end else begin
            pin_meta_reg <= {i_data_memory_select_n, i_rd_n, i_wr_n, i_addr, i_data, 1'b0};
            pin_sync_reg <= pin_meta_reg;
        end
    end
    wire        sel_n  = pin_sync_reg[33];
    wire        rd_n   = pin_sync_reg[32];
    wire        wr_n   = pin_sync_reg[31];
    wire [13:0] addr   = pin_sync_reg[30:17];
    wire [15:0] wdata  = pin_sync_reg[16:1];

    //=================================================================
    // Window decode on the two upper decode lines
    wire [1:0] upper_decode   = addr[13:12];  // upper_decode_line_high/low
    wire       ext_read       = !sel_n && !rd_n;
    wire       ext_write      = !sel_n && !wr_n;
    // Writes never move RAS; only reads in the two row windows do
    wire       row_select     = ext_read && (upper_decode == dram_glue_pkg::UPPER_ROW_WINDOW);
    wire       row_release    = ext_read && (upper_decode == dram_glue_pkg::UPPER_RELEASE_WINDOW);
    // Column window excludes the internal area above 0x3800 and timer words
    wire       column_window  = (upper_decode == dram_glue_pkg::UPPER_COLUMN_WINDOW) && !addr[11];
    wire       column_access  = column_window && (ext_read || ext_write);

    //=================================================================
    // RAS holds state between windows; refresh needs only the two reads
    wire ras_n_next = row_select  ? 1'b0 :
                      row_release ? 1'b1 :
                      o_ras_n;
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_ras_n <= 1'b1;                 // Power up deasserted
        end else begin
            o_ras_n <= ras_n_next;
        end
    end

    //=================================================================
    // CAS follows the column window; stays high during RAS-only refresh
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_cas_n <= 1'b1;
        end else begin
            o_cas_n <= !column_access;
        end
    end

    //=================================================================
    // WRITE is the write strobe delayed one clock behind CAS, so its falling edge
    // lands while the processor still drives valid data
    logic wr_delay_reg;
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_delay_reg <= 1'b1;
            o_write_n    <= 1'b1;
        end else begin
            wr_delay_reg <= !(ext_write && column_window);
            o_write_n    <= wr_delay_reg;
        end
    end

    //=================================================================
    // Output enable straight from read strobe
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_oe_n <= 1'b1;
        end else begin
            o_oe_n <= rd_n;
        end
    end

    //=================================================================
    // DRAM address straight from the sync flops; it settles one clock
    // before RAS or CAS falls, which gives the DRAM its address setup
    assign o_dram_addr = addr[dram_glue_pkg::DRAM_ADDR_W-1:0];

    //=================================================================
    // RAS low-time watchdog; flags a page held past the DRAM limit
    logic [dram_glue_pkg::RAS_CNT_W-1:0] ras_low_cnt_reg;
    localparam logic [dram_glue_pkg::RAS_CNT_W-1:0] RAS_LIMIT =
        dram_glue_pkg::RAS_CNT_W'(dram_glue_pkg::RAS_MAX_LOW_CYCLES);
    wire ras_limit_hit = (ras_low_cnt_reg == RAS_LIMIT);
    // Counter stops at the limit, so the flag holds until RAS rises
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ras_low_cnt_reg <= '0;
            o_ras_overtime  <= 1'b0;
        end else if (o_ras_n) begin
            ras_low_cnt_reg <= '0;
            o_ras_overtime  <= 1'b0;
        end else if (!ras_limit_hit) begin
            ras_low_cnt_reg <= ras_low_cnt_reg + 1'b1;
        end else begin
            o_ras_overtime  <= 1'b1;
        end
    end

    //=================================================================
    // Refresh pacing timer written through the data-memory bus
    logic [15:0] timer_prescale_reg;
    logic [15:0] timer_count_reg;
    logic [15:0] timer_reload_period_reg;
    logic [15:0] prescale_cnt_reg;
    // Timer words lie above the column window, so they never strobe CAS
    wire wr_prescale = ext_write && (addr == dram_glue_pkg::TIMER_PRESCALE_OFS);
    wire wr_count    = ext_write && (addr == dram_glue_pkg::TIMER_COUNT_OFS);
    wire wr_reload   = ext_write && (addr == dram_glue_pkg::TIMER_RELOAD_OFS);
    // A write strobe lasts several clocks; act on its first cycle only
    logic wr_prev_reg;
    wire  wr_first   = !wr_n && wr_prev_reg;
    // Count steps once every prescale+1 clocks
    wire  scale_tick = (prescale_cnt_reg == 16'h0000);
    // A zero count stops the timer until software loads one
    wire  count_run  = (timer_count_reg != 16'h0000);
    wire  expire     = scale_tick && (timer_count_reg == 16'h0001);
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_prev_reg             <= 1'b1;
            timer_prescale_reg      <= dram_glue_pkg::TIMER_RESET_VALUE;
            timer_reload_period_reg <= dram_glue_pkg::TIMER_RESET_VALUE;
            prescale_cnt_reg        <= dram_glue_pkg::TIMER_RESET_VALUE;
        end else begin
            wr_prev_reg <= wr_n;
            if (wr_first && wr_prescale) begin
                timer_prescale_reg <= wdata;
            end
            if (wr_first && wr_reload) begin
                timer_reload_period_reg <= wdata;
            end
            // Writing the prescale restarts the divider at once
            if (scale_tick || (wr_first && wr_prescale)) begin
                prescale_cnt_reg <= wr_prescale ? wdata : timer_prescale_reg;
            end else begin
                prescale_cnt_reg <= prescale_cnt_reg - 16'h0001;
            end
        end
    end

    // Count reload and one-cycle refresh pacing pulse
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            timer_count_reg <= dram_glue_pkg::TIMER_RESET_VALUE;
            o_refresh_tick  <= 1'b0;
        end else begin
            o_refresh_tick <= count_run && expire;
            // A software load wins over expiry in the same clock
            if (wr_first && wr_count) begin
                timer_count_reg <= wdata;
            end else if (expire) begin
                timer_count_reg <= timer_reload_period_reg;
            end else if (scale_tick && count_run) begin
                timer_count_reg <= timer_count_reg - 16'h0001;
            end
        end
    end

    //=================================================================
    // Timer read-back onto the shared data bus
    wire rd_timer = ext_read && (addr >= dram_glue_pkg::TIMER_PRESCALE_OFS)
                             && (addr <= dram_glue_pkg::TIMER_RELOAD_OFS);
    wire [15:0] rd_mux = (addr == dram_glue_pkg::TIMER_PRESCALE_OFS) ? timer_prescale_reg :
                         (addr == dram_glue_pkg::TIMER_COUNT_OFS)    ? timer_count_reg :
                                                                       timer_reload_period_reg;
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_data    <= 16'h0000;
            o_data_oe <= 1'b0;
        end else begin
            // Zero when not driven, so an idle bus never leaks a timer word
            o_data    <= rd_timer ? rd_mux : 16'h0000;
            o_data_oe <= rd_timer;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dram_glue_pkg.sv
// Constants for the mapped DRAM access and refresh glue logic
//=====================================================================
package dram_glue_pkg;
    //=================================================================
    // Address decode
    localparam logic [1:0]  UPPER_ROW_WINDOW     = 2'h1;   // 0x1000 window
    localparam logic [1:0]  UPPER_RELEASE_WINDOW = 2'h2;   // 0x2000 window
    localparam logic [1:0]  UPPER_COLUMN_WINDOW  = 2'h3;   // 0x3000 window
    localparam int          ADDR_W               = 14;
    localparam int          DRAM_ADDR_W          = 10;
    localparam int          DATA_W               = 16;
    //=================================================================
    // Timer register offsets
    localparam logic [13:0] TIMER_PRESCALE_OFS   = 14'h3FFB;
    localparam logic [13:0] TIMER_COUNT_OFS      = 14'h3FFC;
    localparam logic [13:0] TIMER_RELOAD_OFS     = 14'h3FFD;
    localparam logic [15:0] TIMER_RESET_VALUE    = 16'h0000;
    //=================================================================
    // Timing
    localparam int          CLK_HZ               = 20_000_000;
    localparam int          RAS_MAX_LOW_US       = 200;
    localparam int          RAS_MAX_LOW_CYCLES   = RAS_MAX_LOW_US * (CLK_HZ / 1_000_000);
    localparam int          RAS_CNT_W            = 13;
endpackage

// File: testbench/mapped_dram_access_refresh_properties.sv
// Concurrent checks on the DRAM glue block ports
`timescale 1ns/100ps
`default_nettype none
module mapped_dram_access_refresh_properties (
    // Clock, reset and processor pins
    input wire logic        i_clk_sys,
    input wire logic        i_resetn,
    input wire logic        i_data_memory_select_n,
    input wire logic        i_rd_n,
    input wire logic        i_wr_n,
    input wire logic [13:0] i_addr,
    // DRAM pins and status
    input wire logic        o_ras_n,
    input wire logic        o_cas_n,
    input wire logic        o_write_n,
    input wire logic        o_oe_n,
    input wire logic [9:0]  o_dram_addr,
    input wire logic        o_ras_overtime,
    input wire logic        o_refresh_tick
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    //=============================================================
    // Window decodes; the column window stops at addr[11] so timer hits stay out
    wire sel_w  = !i_data_memory_select_n;
    wire row_rd = sel_w && !i_rd_n && i_addr[13:12] == dram_glue_pkg::UPPER_ROW_WINDOW;
    wire rel_rd = sel_w && !i_rd_n && i_addr[13:12] == dram_glue_pkg::UPPER_RELEASE_WINDOW;
    wire col_hit = i_addr[13:12] == dram_glue_pkg::UPPER_COLUMN_WINDOW && !i_addr[11];
    wire col_acc = sel_w && (!i_rd_n || !i_wr_n) && col_hit;
    //=============================================================
    // Pin to strobe relations, three edges through sync and output flops, four for the delayed WRITE
    ras_set_a: assert property (row_rd |-> ##3 !o_ras_n)
        else $error("RAS not low after row read");
    ras_clear_a: assert property (rel_rd |-> ##3 o_ras_n)
        else $error("RAS not high after release read");
    ras_hold_a: assert property (!row_rd && !rel_rd |-> ##3 $stable(o_ras_n))
        else $error("RAS moved without a window read");
    cas_low_a: assert property (col_acc |-> ##3 !o_cas_n)
        else $error("CAS not low in column access");
    cas_high_a: assert property (!col_acc |-> ##3 o_cas_n)
        else $error("CAS low outside column access");
    write_delay_a: assert property (col_acc && !i_wr_n |-> ##4 !o_write_n)
        else $error("WRITE not low one clock after CAS");
    write_idle_a: assert property (i_wr_n |-> ##4 o_write_n)
        else $error("WRITE low without a write strobe");
    oe_follow_a: assert property (o_oe_n == $past(i_rd_n, 3))
        else $error("OE does not follow read strobe");
    col_addr_a: assert property ($fell(o_cas_n) |-> $stable(o_dram_addr)
        && o_dram_addr == $past(i_addr[9:0], 2))
        else $error("Column address not settled at CAS fall");
    tick_pulse_a: assert property (o_refresh_tick |=> !o_refresh_tick)
        else $error("Refresh tick longer than one clock");
    overtime_clr_a: assert property (o_ras_n [*2] |-> !o_ras_overtime)
        else $error("Overtime flag set while RAS high");
    // Main scenarios
    cover property (row_rd ##3 !o_ras_n);
    cover property (col_acc && !i_wr_n ##4 !o_write_n);
    cover property (o_refresh_tick);
endmodule
bind mapped_dram_access_refresh mapped_dram_access_refresh_properties i_props (.*);
`default_nettype wire

// File: testbench/dram_model.sv
// Behavioural model of the four parallel DRAMs on the strobes
`timescale 1ns/100ps
`default_nettype none
module dram_model (
    // Strobes and address from the glue
    input  wire logic        i_ras_n,
    input  wire logic        i_cas_n,
    input  wire logic        i_write_n,
    input  wire logic        i_oe_n,
    input  wire logic [9:0]  i_addr,
    input  wire logic [15:0] i_dq,
    // Read data and observation
    output logic      [15:0] o_dq,
    output logic      [9:0]  o_row,
    output logic      [15:0] o_cas_cnt
);
    logic [15:0] mem [int];
    logic [15:0] rd_reg = 16'h0000;
    logic [15:0] last_reg = 16'h0000;
    logic [9:0]  col_reg = 10'h000;
    initial o_cas_cnt = 16'h0000;
    // Row activation latches the row and refreshes it
    always @(negedge i_ras_n) o_row = i_addr;
    // Column access starts as soon as the column is latched
    always @(negedge i_cas_n) begin
        col_reg = i_addr;
        o_cas_cnt++;
        rd_reg = mem.exists({o_row, i_addr}) ? mem[{o_row, i_addr}] : ~last_reg;
    end
    // Delayed write: data taken at the WRITE fall inside CAS
    always @(negedge i_write_n) if (!i_cas_n) mem[{o_row, col_reg}] = i_dq;
    // Released bus shows the inverse so a stale value never matches
    always @(posedge i_cas_n) last_reg = o_dq;
    assign o_dq = (!i_oe_n && !i_cas_n) ? rd_reg : ~last_reg;
endmodule
`default_nettype wire

// File: testbench/mapped_dram_access_refresh_tb_top.sv
// Self-checking bench for the DRAM glue block
`timescale 1ns/100ps
`default_nettype none
module mapped_dram_access_refresh_tb_top;
    //=============================================================
    // Pins, named as the design ports
    logic        i_clk_sys, i_resetn, i_data_memory_select_n, i_rd_n, i_wr_n;
    logic        o_data_oe, o_ras_n, o_cas_n, o_write_n, o_oe_n, o_ras_overtime;
    logic        o_refresh_tick;
    logic [13:0] i_addr;
    logic [15:0] i_data, o_data, dq, q, t, cas_cnt, c0;
    logic [9:0]  o_dram_addr, row;
    int          num_errors, num_checks, n;
    logic [13:0] cols [3] = '{14'h3123, 14'h3456, 14'h3789};
    mapped_dram_access_refresh i_mapped_dram_access_refresh (.*);
    dram_model i_dram_model (.i_ras_n(o_ras_n), .i_cas_n(o_cas_n), .i_write_n(o_write_n),
        .i_oe_n(o_oe_n), .i_addr(o_dram_addr), .i_dq(i_data), .o_dq(dq), .o_row(row),
        .o_cas_cnt(cas_cnt));
    always #25 i_clk_sys = ~i_clk_sys;
    //=============================================================
    // Tasks
    task automatic final_report;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Held four clocks: covers the pin sync delay, the CAS flop and the delayed WRITE clock
    task automatic acc(input logic [13:0] a, input logic w, input logic [15:0] d);
        @(posedge i_clk_sys) #1;
        i_addr = a;
        i_data = d;
        i_data_memory_select_n = 0;
        i_rd_n = w;
        i_wr_n = !w;
        repeat (4) @(posedge i_clk_sys);
        #1 q = dq;
        t = o_data;
        i_data_memory_select_n = 1;
        i_rd_n = 1;
        i_wr_n = 1;
    endtask
    task automatic tick_wait;
        n = 0;
        do begin
            @(posedge i_clk_sys) #1;
            n++;
        end while (o_refresh_tick !== 1'b1 && n < 200);
    endtask
    //=============================================================
    // Main sequence
    initial begin
        i_clk_sys = 0;
        i_resetn = 0;
        {i_data_memory_select_n, i_rd_n, i_wr_n} = 3'h7;
        i_addr = 0;
        i_data = 0;
        repeat (20) @(posedge i_clk_sys);
        #1 i_resetn = 1;
        repeat (3) @(posedge i_clk_sys);
        #1 chk("idle", {o_ras_n, o_cas_n, o_write_n, o_oe_n}, 16'hF);
        acc(14'h1ABC, 0, 0);
        chk("row", o_ras_n, 0);
        for (int i = 0; i < 3; i++) acc(cols[i], 1, 16'hA000 ^ cols[i]);
        chk("page", o_ras_n, 0);
        acc(14'h2000, 0, 0);
        chk("release", o_ras_n, 1);
        repeat (2) @(posedge i_clk_sys); // Precharge idle
        acc(14'h1ABC, 0, 0);
        for (int i = 0; i < 3; i++) begin
            acc(cols[i], 0, 0);
            chk("page read", q, 16'hA000 ^ cols[i]);
            chk("dram rd oe", o_data_oe, 0);
        end
        // Column address above the window must leave CAS alone
        c0 = cas_cnt;
        acc(14'h3900, 1, 16'hBEEF);
        chk("refused", cas_cnt, c0);
        acc(14'h2000, 0, 0);
        // RAS-only burst refresh of every row, bank by bank, between access pairs
        for (int b = 0; b < 4; b++) begin
            for (int r = 0; r < 256; r++) begin
                acc(14'h1000 + 14'((b << 8) + r), 0, 0);
                acc(14'h2000, 0, 0);
                chk("ref row", row, 16'((b << 8) + r));
                chk("ref cas", cas_cnt, c0);
            end
        end
        // Reload 4 at prescale 2 gives a tick every 12 clocks
        acc(14'h3FFB, 1, 2);
        acc(14'h3FFD, 1, 4);
        acc(14'h3FFC, 1, 4);
        acc(14'h3FFD, 0, 0);
        chk("reload", t, 4);
        chk("reload oe", o_data_oe, 1);
        tick_wait();
        tick_wait();
        chk("period", 16'(n), 12);
        // RAS held low past its limit raises the overtime flag
        acc(14'h1000, 0, 0);
        repeat (4000) @(posedge i_clk_sys);
        #1 chk("overtime", o_ras_overtime, 1);
        acc(14'h2000, 0, 0);
        @(posedge i_clk_sys);
        #1 chk("overtime clr", o_ras_overtime, 0);
        final_report();
    end
    // Watchdog: about 15,000 clocks expected, mostly the burst refresh
    initial begin
        repeat (40000) @(posedge i_clk_sys);
        num_errors++;
        final_report();
    end
endmodule
`default_nettype wire
